// >>> rtl/ext_bus_timing.v
// Behaviour
// R1 - Each SDRAM bank has its own timing register for its accesses.
// R2 - Row-to-column, precharge and row-active fields of value n give n+1 clocks.
// R3 - Four I/O banks each have their own control register.
// R4 - An I/O bank starts at its base pointer shifted left by eighteen.
// R5 - An access hits a bank when base <= address < base plus size.
// R6 - Size code 0 is 256K, doubling per step up to 16M at code 6; code 7 is reserved.
// R7 - Strobe codes 1 to 7 give 1 to 7 clocks, then 9 up to 23 in steps of 2.
// R8 - The address is held for the setup field's count of clocks before chip select falls.
// R9 - Writing one to the init trigger bit starts the same SDRAM power-on sequence as reset.
// R10 - The init trigger bit clears itself when the SDRAM sequence is complete.
// R11 - The clock tree is sampled on rising and falling edges into the two reference bytes.
// R12 - Output delay and latch skew fields: edge select on top, 0 to 7 gate steps below.
// R13 - I/O address decoding and strobe timing are made inside the block.
// R14 - The select-to-strobe field of value n delays the strobe n+1 clocks (1 to 8) after chip select.
// R15 - The select hold field of value n keeps chip select low n+1 clocks (1 to 8) after the strobe ends.
// R16 - The write recovery field gives 1 to 4 clocks between last write data and precharge.
`include "ext_bus_map.vh"
`default_nettype none

module ext_bus_timing #(
  parameter TAP_W = 8
) (
  input wire CLK, // System clock, 125 MHz
  input wire NRST, // Async reset, low
  input wire WB_CYC_I, // Bus cycle
  input wire WB_STB_I, // Bus strobe
  input wire WB_WE_I, // Bus write enable
  input wire [31:0] WB_ADR_I, // Bus byte address
  input wire [31:0] WB_DAT_I, // Bus write data
  input wire [3:0] WB_SEL_I, // Bus byte selects
  output reg [31:0] WB_DAT_O, // Bus read data
  output reg WB_ACK_O, // Bus acknowledge
  input wire REQ_VALID, // I/O access request
  output wire REQ_READY, // I/O engine idle
  input wire [31:0] REQ_ADDR, // I/O access address
  input wire REQ_WE, // I/O access is a write
  input wire [3:0] REQ_SEL, // I/O access byte lanes
  input wire [31:0] REQ_WDATA, // I/O write data
  output reg RSP_VALID, // I/O access finished, one cycle
  output reg RSP_ERR, // Address hit no I/O bank
  output reg [31:0] RSP_RDATA, // I/O read data
  output reg [31:0] IO_ADDR, // External address pins
  output reg [3:0] IO_BANK_SELECT_N, // I/O bank chip selects
  output reg READ_STROBE_N, // Read strobe
  output reg WRITE_STROBE_N, // Write strobe
  output reg [3:0] BYTE_WRITE_STROBE_N, // Byte write strobes
  output reg [31:0] IO_DATA_OUT, // Data pin output value
  output reg IO_DATA_OE, // Data pin output enable
  input wire [31:0] IO_DATA_IN, // Data pin input value
  input wire SD_REQ_VALID, // SDRAM access request
  output wire SD_REQ_READY, // SDRAM engine idle
  input wire SD_REQ_BANK, // SDRAM bank of the request
  input wire SD_REQ_WE, // SDRAM request is a write
  output reg SD_DONE, // SDRAM access finished, one cycle
  output reg [2:0] SD_CMD, // SDRAM command
  output reg SD_CMD_BANK, // SDRAM bank of the command
  output reg SD_INIT_BUSY, // Power-on sequence in progress
  input wire [TAP_W-1:0] MCLK_TREE_TAP, // Delayed memory clock tree
  output wire [3:0] MCLK_OUT_DELAY, // Output clock delay select
  output wire [3:0] LATCH_CLOCK_SKEW_SEL // Data latch clock skew select
);

  localparam IO_IDLE = 5'h01;
  localparam IO_SETUP = 5'h02;
  localparam IO_SEL = 5'h04;
  localparam IO_STRB = 5'h08;
  localparam IO_HOLD = 5'h10;

  localparam SD_IDLE = 4'h1;
  localparam SD_RCD = 4'h2;
  localparam SD_RECOV = 4'h4;
  localparam SD_RP = 4'h8;

  reg [31:0] sd_timing_reg [0:1];
  reg [31:0] io_ctl_reg [0:3];
  reg [8:0] skew_reg;
  reg sw_init_reg;
  reg [4:0] io_state_reg;
  reg [4:0] io_cnt_reg;
  reg [31:0] io_act_ctl_reg;
  reg [1:0] io_bank_reg;
  reg io_we_reg;
  reg [3:0] io_sel_reg;
  reg [31:0] din_s1_reg;
  reg [31:0] din_s2_reg;
  reg [3:0] sd_state_reg;
  reg [2:0] sd_cnt_reg;
  reg [2:0] sd_ras_reg;
  reg sd_bank_reg;
  reg sd_we_reg;
  reg sd_init_reg;
  reg [1:0] sd_step_reg;
  wire [TAP_W-1:0] tap_rise;
  wire [TAP_W-1:0] tap_fall;
  wire [3:0] io_hit;
  wire wb_req;
  wire wb_wr;
  wire sw_init_set;
  wire sd_init_done;
  wire [31:0] cur_sd;
  wire [31:0] req_ctl;
  wire [1:0] io_idx;
  reg [1:0] hit_bank;
  reg [31:0] rd_mux;

  function [31:0] merge_bytes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    input [31:0] mask;
    integer b;
    begin
      merge_bytes = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          merge_bytes[b*8 +: 8] = new_v[b*8 +: 8];
      merge_bytes = merge_bytes & mask;
    end
  endfunction

  function bank_hit;
    input [31:0] a;
    input [31:0] ctl;
    reg [32:0] base;
    reg [32:0] size;
    begin
      base = {2'b00, ctl[`BANK_BASE_POINTER_MSB:`BANK_BASE_POINTER_LSB], 18'h00000}; // [R4]
      size = `BANK_SIZE_MIN << ctl[`BANK_SIZE_MSB:`BANK_SIZE_LSB]; // [R6]
      bank_hit = (ctl[`BANK_SIZE_MSB:`BANK_SIZE_LSB] != `BANK_SIZE_RESERVED) &&
                 (ctl[`BANK_BUS_WIDTH_MSB:`BANK_BUS_WIDTH_LSB] != 2'h0) &&
                 ({1'b0, a} >= base) && ({1'b0, a} < base + size); // [R5]
    end
  endfunction

  function [4:0] strobe_len;
    input [3:0] code;
    begin
      if (code == 4'h0)
        strobe_len = 5'h01;
      else if (!code[3])
        strobe_len = {1'b0, code}; // [R7]
      else
        strobe_len = {code, 1'b0} - 5'h07; // [R7]
    end
  endfunction

  function [31:0] pin_address;
    input [31:0] a;
    input [31:0] ctl;
    begin
      if (ctl[`BYTE_ADDRESS_ALIGNMENT_BIT] || ctl[`BANK_BUS_WIDTH_MSB:`BANK_BUS_WIDTH_LSB] == 2'h1)
        pin_address = a;
      else if (ctl[`BANK_BUS_WIDTH_MSB:`BANK_BUS_WIDTH_LSB] == 2'h2)
        pin_address = {1'b0, a[31:1]};
      else
        pin_address = {2'b00, a[31:2]};
    end
  endfunction

  tap_sampler #(
    .W(TAP_W)
  ) u_tap_sampler (
    .clk(CLK),
    .nrst(NRST),
    .tap(MCLK_TREE_TAP),
    .rise_q(tap_rise),
    .fall_q(tap_fall)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_hit
      assign io_hit[gi] = bank_hit(REQ_ADDR, io_ctl_reg[gi]); // [R13]
    end
  endgenerate

  always @*
  begin
    hit_bank = 2'h0;
    if (io_hit[0])
      hit_bank = 2'h0;
    else if (io_hit[1])
      hit_bank = 2'h1;
    else if (io_hit[2])
      hit_bank = 2'h2;
    else if (io_hit[3])
      hit_bank = 2'h3;
  end

  assign req_ctl = io_ctl_reg[hit_bank];
  // I/O control offsets 0x18..0x24 map to index 0..3
  assign io_idx = WB_ADR_I[3:2] - 2'h2;
  assign wb_req = WB_CYC_I & WB_STB_I;
  assign wb_wr = wb_req & WB_WE_I & WB_ACK_O;
  assign sw_init_set = wb_wr && WB_SEL_I[1] && WB_ADR_I == `ADDR_CLOCK_SKEW_CONTROL &&
                       WB_DAT_I[`SW_SDRAM_INIT_TRIGGER_BIT];
  assign MCLK_OUT_DELAY = skew_reg[`MCLK_OUT_DELAY_MSB:`MCLK_OUT_DELAY_LSB]; // [R12]
  assign LATCH_CLOCK_SKEW_SEL = skew_reg[`LATCH_CLOCK_SKEW_SEL_MSB:`LATCH_CLOCK_SKEW_SEL_LSB]; // [R12]
  assign REQ_READY = io_state_reg == IO_IDLE;

  always @*
  begin
    case (WB_ADR_I)
      `ADDR_SDRAM_BANK0_TIMING: rd_mux = sd_timing_reg[0];
      `ADDR_SDRAM_BANK1_TIMING: rd_mux = sd_timing_reg[1];
      `ADDR_IO_BANK0_CONTROL, `ADDR_IO_BANK1_CONTROL, `ADDR_IO_BANK2_CONTROL, `ADDR_IO_BANK3_CONTROL:
        rd_mux = io_ctl_reg[io_idx];
      `ADDR_CLOCK_SKEW_CONTROL: rd_mux = {tap_rise, tap_fall, 7'h00, sw_init_reg, skew_reg[7:0]}; // [R11]
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Register slave, ack one cycle after request
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      sd_timing_reg[0] <= `RST_SDRAM_TIMING;
      sd_timing_reg[1] <= `RST_SDRAM_TIMING;
      io_ctl_reg[0] <= `RST_IO_CONTROL;
      io_ctl_reg[1] <= `RST_IO_CONTROL;
      io_ctl_reg[2] <= `RST_IO_CONTROL;
      io_ctl_reg[3] <= `RST_IO_CONTROL;
      skew_reg <= `RST_CLOCK_SKEW_LOW;
      sw_init_reg <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      if (wb_req & ~WB_ACK_O)
        WB_DAT_O <= rd_mux;
      if (wb_wr)
      begin
        case (WB_ADR_I)
          `ADDR_SDRAM_BANK0_TIMING: sd_timing_reg[0] <=
            merge_bytes(sd_timing_reg[0], WB_DAT_I, WB_SEL_I, `MASK_SDRAM_TIMING); // [R1]
          `ADDR_SDRAM_BANK1_TIMING: sd_timing_reg[1] <=
            merge_bytes(sd_timing_reg[1], WB_DAT_I, WB_SEL_I, `MASK_SDRAM_TIMING); // [R1]
          `ADDR_IO_BANK0_CONTROL, `ADDR_IO_BANK1_CONTROL, `ADDR_IO_BANK2_CONTROL, `ADDR_IO_BANK3_CONTROL:
            io_ctl_reg[io_idx] <= merge_bytes(io_ctl_reg[io_idx], WB_DAT_I, WB_SEL_I, `MASK_IO_CONTROL); // [R3]
          `ADDR_CLOCK_SKEW_CONTROL:
            if (WB_SEL_I[0])
              skew_reg[7:0] <= WB_DAT_I[7:0]; // [R12]
          default:
            skew_reg <= skew_reg;
        endcase
      end
      // Trigger wins over completion
      if (sw_init_set)
        sw_init_reg <= 1'b1; // [R9]
      else if (sd_init_done)
        sw_init_reg <= 1'b0; // [R10]
    end
  end

  // I/O bank access sequencer
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      din_s1_reg <= 32'h00000000;
      din_s2_reg <= 32'h00000000;
      io_state_reg <= IO_IDLE;
      io_cnt_reg <= 5'h00;
      io_act_ctl_reg <= 32'h00000000;
      io_bank_reg <= 2'h0;
      io_we_reg <= 1'b0;
      io_sel_reg <= 4'h0;
      RSP_VALID <= 1'b0;
      RSP_ERR <= 1'b0;
      RSP_RDATA <= 32'h00000000;
      IO_ADDR <= 32'h00000000;
      IO_BANK_SELECT_N <= 4'hF;
      READ_STROBE_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      BYTE_WRITE_STROBE_N <= 4'hF;
      IO_DATA_OUT <= 32'h00000000;
      IO_DATA_OE <= 1'b0;
    end
    else
    begin
      din_s1_reg <= IO_DATA_IN;
      din_s2_reg <= din_s1_reg;
      RSP_VALID <= 1'b0;
      case (io_state_reg)
        IO_IDLE:
          if (REQ_VALID)
          begin
            if (io_hit == 4'h0)
            begin
              RSP_VALID <= 1'b1;
              RSP_ERR <= 1'b1;
            end
            else
            begin
              RSP_ERR <= 1'b0;
              io_act_ctl_reg <= req_ctl;
              io_bank_reg <= hit_bank;
              io_we_reg <= REQ_WE;
              io_sel_reg <= REQ_SEL;
              IO_ADDR <= pin_address(REQ_ADDR, req_ctl); // [R13]
              IO_DATA_OUT <= REQ_WDATA;
              IO_DATA_OE <= REQ_WE;
              if (req_ctl[`ADDR_SETUP_BEFORE_SELECT_MSB:`ADDR_SETUP_BEFORE_SELECT_LSB] != 3'h0)
              begin
                io_state_reg <= IO_SETUP; // [R8]
                io_cnt_reg <= {2'b00, req_ctl[`ADDR_SETUP_BEFORE_SELECT_MSB:`ADDR_SETUP_BEFORE_SELECT_LSB]} - 5'h01;
              end
              else
              begin
                IO_BANK_SELECT_N <= ~(4'h1 << hit_bank);
                io_state_reg <= IO_SEL;
                io_cnt_reg <= 5'h00;
              end
            end
          end
        IO_SETUP:
          if (io_cnt_reg == 5'h00)
          begin
            IO_BANK_SELECT_N <= ~(4'h1 << io_bank_reg); // [R8]
            io_state_reg <= IO_SEL;
          end
          else
            io_cnt_reg <= io_cnt_reg - 5'h01;
        IO_SEL:
          // Select-to-strobe count
          if (io_cnt_reg == {2'b00, io_act_ctl_reg[`SELECT_SETUP_BEFORE_STROBE_MSB:`SELECT_SETUP_BEFORE_STROBE_LSB]})
          begin
            READ_STROBE_N <= io_we_reg; // [R14]
            WRITE_STROBE_N <= ~io_we_reg;
            BYTE_WRITE_STROBE_N <= io_we_reg ? ~io_sel_reg : 4'hF;
            io_cnt_reg <= strobe_len(io_act_ctl_reg[`STROBE_ACTIVE_CYCLES_MSB:`STROBE_ACTIVE_CYCLES_LSB]) - 5'h01;
            io_state_reg <= IO_STRB;
          end
          else
            io_cnt_reg <= io_cnt_reg + 5'h01;
        IO_STRB:
          if (io_cnt_reg == 5'h00)
          begin
            READ_STROBE_N <= 1'b1; // [R7]
            WRITE_STROBE_N <= 1'b1;
            BYTE_WRITE_STROBE_N <= 4'hF;
            RSP_RDATA <= io_we_reg ? 32'h00000000 : din_s2_reg;
            io_cnt_reg <= 5'h00;
            io_state_reg <= IO_HOLD;
          end
          else
            io_cnt_reg <= io_cnt_reg - 5'h01;
        IO_HOLD:
          if (io_cnt_reg == {2'b00, io_act_ctl_reg[`SELECT_HOLD_AFTER_STROBE_MSB:`SELECT_HOLD_AFTER_STROBE_LSB]})
          begin
            IO_BANK_SELECT_N <= 4'hF; // [R15]
            IO_DATA_OE <= 1'b0;
            RSP_VALID <= 1'b1;
            io_state_reg <= IO_IDLE;
          end
          else
            io_cnt_reg <= io_cnt_reg + 5'h01;
        default:
          io_state_reg <= IO_IDLE;
      endcase
    end
  end

  // SDRAM sequencer, per-bank timing
  assign cur_sd = sd_timing_reg[sd_bank_reg]; // [R1]
  assign SD_REQ_READY = sd_state_reg == SD_IDLE && !sd_init_reg && !sw_init_reg;
  assign sd_init_done = sd_state_reg == SD_RP && sd_init_reg && sd_cnt_reg == 3'h0 &&
                        sd_step_reg == `SD_INIT_REFRESHES;

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sd_state_reg <= SD_IDLE;
      sd_cnt_reg <= 3'h0;
      sd_ras_reg <= 3'h0;
      sd_bank_reg <= 1'b0;
      sd_we_reg <= 1'b0;
      sd_init_reg <= 1'b1;
      sd_step_reg <= 2'h0;
      SD_CMD <= `SD_CMD_NOP;
      SD_CMD_BANK <= 1'b0;
      SD_DONE <= 1'b0;
      SD_INIT_BUSY <= 1'b1;
    end
    else
    begin
      SD_CMD <= `SD_CMD_NOP;
      SD_DONE <= 1'b0;
      if (sd_ras_reg != 3'h0)
        sd_ras_reg <= sd_ras_reg - 3'h1;
      case (sd_state_reg)
        SD_IDLE:
          if (sd_init_reg || sw_init_reg)
          begin
            sd_init_reg <= 1'b1; // [R9]
            SD_INIT_BUSY <= 1'b1;
            sd_step_reg <= 2'h0;
            sd_bank_reg <= 1'b0;
            SD_CMD <= `SD_CMD_PRECHARGE;
            sd_cnt_reg <= sd_timing_reg[0][`ROW_PRECHARGE_TIME_MSB:`ROW_PRECHARGE_TIME_LSB];
            sd_state_reg <= SD_RP;
          end
          else if (SD_REQ_VALID)
          begin
            sd_bank_reg <= SD_REQ_BANK;
            sd_we_reg <= SD_REQ_WE;
            SD_CMD <= `SD_CMD_ACTIVE;
            SD_CMD_BANK <= SD_REQ_BANK;
            sd_cnt_reg <= sd_timing_reg[SD_REQ_BANK][`ROW_TO_COL_DELAY_MSB:`ROW_TO_COL_DELAY_LSB]; // [R2]
            sd_ras_reg <= sd_timing_reg[SD_REQ_BANK][`ROW_ACTIVE_TIME_MSB:`ROW_ACTIVE_TIME_LSB]; // [R2]
            sd_state_reg <= SD_RCD;
          end
        SD_RCD:
          if (sd_cnt_reg == 3'h0)
          begin
            SD_CMD <= sd_we_reg ? `SD_CMD_WRITE : `SD_CMD_READ;
            sd_cnt_reg <= sd_we_reg ?
              {1'b0, cur_sd[`WRITE_RECOVERY_TIME_MSB:`WRITE_RECOVERY_TIME_LSB]} : 3'h0; // [R16]
            sd_state_reg <= SD_RECOV;
          end
          else
            sd_cnt_reg <= sd_cnt_reg - 3'h1;
        SD_RECOV:
          if (sd_cnt_reg == 3'h0 && sd_ras_reg == 3'h0)
          begin
            SD_CMD <= `SD_CMD_PRECHARGE; // [R2]
            sd_cnt_reg <= cur_sd[`ROW_PRECHARGE_TIME_MSB:`ROW_PRECHARGE_TIME_LSB];
            sd_state_reg <= SD_RP;
          end
          else if (sd_cnt_reg != 3'h0)
            sd_cnt_reg <= sd_cnt_reg - 3'h1;
        SD_RP:
          if (sd_cnt_reg != 3'h0)
            sd_cnt_reg <= sd_cnt_reg - 3'h1;
          else if (!sd_init_reg)
          begin
            SD_DONE <= 1'b1; // [R2]
            sd_state_reg <= SD_IDLE;
          end
          else if (sd_step_reg != `SD_INIT_REFRESHES)
          begin
            SD_CMD <= `SD_CMD_REFRESH; // [R9]
            sd_step_reg <= sd_step_reg + 2'h1;
            sd_cnt_reg <= cur_sd[`ROW_PRECHARGE_TIME_MSB:`ROW_PRECHARGE_TIME_LSB];
          end
          else
          begin
            SD_CMD <= `SD_CMD_MODE_SET; // [R10]
            sd_init_reg <= 1'b0;
            SD_INIT_BUSY <= 1'b0;
            sd_state_reg <= SD_IDLE;
          end
        default:
          sd_state_reg <= SD_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> rtl/ext_bus_map.vh
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH

// Register byte addresses
`define ADDR_SDRAM_BANK0_TIMING 32'hFFF01010
`define ADDR_SDRAM_BANK1_TIMING 32'hFFF01014
`define ADDR_IO_BANK0_CONTROL 32'hFFF01018
`define ADDR_IO_BANK1_CONTROL 32'hFFF0101C
`define ADDR_IO_BANK2_CONTROL 32'hFFF01020
`define ADDR_IO_BANK3_CONTROL 32'hFFF01024
`define ADDR_CLOCK_SKEW_CONTROL 32'hFFF01F00

// Reset values
`define RST_SDRAM_TIMING 32'h00000000
`define RST_IO_CONTROL 32'h00000000
`define RST_CLOCK_SKEW_LOW 9'h018

// Writable masks
`define MASK_SDRAM_TIMING 32'h000007FF
`define MASK_IO_CONTROL 32'hFFFFFFFF

// SDRAM timing fields
`define ROW_TO_COL_DELAY_MSB 10
`define ROW_TO_COL_DELAY_LSB 8
`define WRITE_RECOVERY_TIME_MSB 7
`define WRITE_RECOVERY_TIME_LSB 6
`define ROW_PRECHARGE_TIME_MSB 5
`define ROW_PRECHARGE_TIME_LSB 3
`define ROW_ACTIVE_TIME_MSB 2
`define ROW_ACTIVE_TIME_LSB 0

// I/O bank control fields
`define BANK_BASE_POINTER_MSB 31
`define BANK_BASE_POINTER_LSB 19
`define BANK_SIZE_MSB 18
`define BANK_SIZE_LSB 16
`define BYTE_ADDRESS_ALIGNMENT_BIT 15
`define STROBE_ACTIVE_CYCLES_MSB 14
`define STROBE_ACTIVE_CYCLES_LSB 11
`define SELECT_HOLD_AFTER_STROBE_MSB 10
`define SELECT_HOLD_AFTER_STROBE_LSB 8
`define ADDR_SETUP_BEFORE_SELECT_MSB 7
`define ADDR_SETUP_BEFORE_SELECT_LSB 5
`define SELECT_SETUP_BEFORE_STROBE_MSB 4
`define SELECT_SETUP_BEFORE_STROBE_LSB 2
`define BANK_BUS_WIDTH_MSB 1
`define BANK_BUS_WIDTH_LSB 0
`define BANK_BASE_SHIFT 18
`define BANK_SIZE_MIN 33'h000040000
`define BANK_SIZE_RESERVED 3'h7

// Clock skew fields
`define LATCH_CLOCK_SAMPLE_REF_RISE_MSB 31
`define LATCH_CLOCK_SAMPLE_REF_RISE_LSB 24
`define LATCH_CLOCK_SAMPLE_REF_FALL_MSB 23
`define LATCH_CLOCK_SAMPLE_REF_FALL_LSB 16
`define SW_SDRAM_INIT_TRIGGER_BIT 8
`define LATCH_CLOCK_SKEW_SEL_MSB 7
`define LATCH_CLOCK_SKEW_SEL_LSB 4
`define MCLK_OUT_DELAY_MSB 3
`define MCLK_OUT_DELAY_LSB 0

// SDRAM command codes
`define SD_CMD_NOP 3'h0
`define SD_CMD_ACTIVE 3'h1
`define SD_CMD_READ 3'h2
`define SD_CMD_WRITE 3'h3
`define SD_CMD_PRECHARGE 3'h4
`define SD_CMD_REFRESH 3'h5
`define SD_CMD_MODE_SET 3'h6

// Refresh commands in the power-on sequence
`define SD_INIT_REFRESHES 2'h2

`endif

// >>> rtl/tap_sampler.v
`default_nettype none

module tap_sampler #(
  parameter W = 8
) (
  input wire clk, // System clock
  input wire nrst, // Async reset, low
  input wire [W-1:0] tap, // Delayed clock tree taps
  output reg [W-1:0] rise_q, // Taps seen at rising edges
  output reg [W-1:0] fall_q // Taps seen at falling edges
);

  reg [W-1:0] rise_s1_reg;
  reg [W-1:0] fall_s1_reg;

  // Two-stage capture on each edge
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rise_s1_reg <= {W{1'b0}};
      rise_q <= {W{1'b0}};
    end
    else
    begin
      rise_s1_reg <= tap;
      rise_q <= rise_s1_reg;
    end
  end

  always @(negedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fall_s1_reg <= {W{1'b0}};
      fall_q <= {W{1'b0}};
    end
    else
    begin
      fall_s1_reg <= tap;
      fall_q <= fall_s1_reg;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/ext_bus_timing_monitor.sv
`include "ext_bus_map.vh"
`default_nettype none
module ext_bus_timing_monitor (
  input wire logic CLK, // Clock
  input wire logic NRST, // Reset, low
  input wire logic WB_CYC_I, // Cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_WE_I, // Write
  input wire logic [31:0] WB_ADR_I, // Address
  input wire logic [3:0] WB_SEL_I, // Lanes
  input wire logic WB_ACK_O, // Ack
  input wire logic REQ_VALID, // I/O request
  input wire logic REQ_READY, // I/O idle
  input wire logic RSP_VALID, // I/O done
  input wire logic [31:0] IO_ADDR, // Pin address
  input wire logic [3:0] IO_BANK_SELECT_N, // Selects
  input wire logic READ_STROBE_N, // Read strobe
  input wire logic WRITE_STROBE_N, // Write strobe
  input wire logic SD_INIT_BUSY, // Init running
  input wire logic SD_REQ_READY, // SDRAM idle
  input wire logic [3:0] MCLK_OUT_DELAY // Clock delay
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  property p_ack_one;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack late");
  property p_ack_drop;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack long");
  property p_init_block;
    SD_INIT_BUSY |-> !SD_REQ_READY;
  endproperty
  a_init_block: assert property (p_init_block) else $error("ready in init");
  property p_skew;
    $changed(MCLK_OUT_DELAY) |-> $past(WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `ADDR_CLOCK_SKEW_CONTROL);
  endproperty
  a_skew: assert property (p_skew) else $error("delay moved");
  property p_strobe_sel;
    !READ_STROBE_N || !WRITE_STROBE_N |-> IO_BANK_SELECT_N != 4'hF;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe unselected");
  property p_onehot;
    IO_BANK_SELECT_N != 4'hF |-> $onehot(~IO_BANK_SELECT_N) && READ_STROBE_N | WRITE_STROBE_N;
  endproperty
  a_onehot: assert property (p_onehot) else $error("select clash");
  property p_addr_hold;
    IO_BANK_SELECT_N != 4'hF && $past(IO_BANK_SELECT_N) != 4'hF |-> $stable(IO_ADDR);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_req_busy;
    REQ_VALID && REQ_READY |=> !REQ_READY || RSP_VALID;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("ready while busy");
endmodule
bind ext_bus_timing ext_bus_timing_monitor i_mon (.CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_SEL_I, .WB_ACK_O, .REQ_VALID, .REQ_READY, .RSP_VALID, .IO_ADDR, .IO_BANK_SELECT_N, .READ_STROBE_N,
  .WRITE_STROBE_N, .SD_INIT_BUSY, .SD_REQ_READY, .MCLK_OUT_DELAY);
`default_nettype wire

// >>> testbench/io_dev_model.sv
`default_nettype none
module io_dev_model #(
  parameter logic [31:0] KEY = 32'h5A5A0F0F
) (
  input wire logic clk, // Clock
  input wire logic [3:0] sel_n, // Bank selects
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic [31:0] addr, // Pin address
  input wire logic [31:0] dout, // Data from block
  output logic [31:0] din, // Data to block
  output logic [31:0] wr_last // Word seen under write strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] held = 32'h0;
  // Idle bus toggles
  assign din = (sel_n != 4'hF && !rd_n) ? addr ^ KEY : ~held;
  always @(posedge clk)
  begin
    held <= din;
    if (sel_n != 4'hF && !wr_n)
      wr_last <= dout;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`include "ext_bus_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] KEY = 32'h3C96A517;
  logic CLK, NRST, cyc, stb, we, rv, rwe, sdv, sdb, sdwe;
  logic [31:0] adr, dat, ra, rwd, rdq, cfg, a, wd, sz, tm[2];
  logic [3:0] sel, rsel;
  logic [7:0] tap;
  wire [31:0] wdo, rrd, ioa, iodo, din, wlast;
  wire ack, rdy, rsv, rse, sdr, sdd, cb, busy, ioe, rdn, wrn;
  wire [3:0] csn, bwn, mod, lsk;
  wire [2:0] cmd;
  integer seed = 76853;
  int fail_count = 0, samples_checked = 0, c[4], n, k, t, t0, t1;
  ext_bus_timing i_ext_bus_timing (.CLK, .NRST, .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(wdo), .WB_ACK_O(ack), .REQ_VALID(rv),
    .REQ_READY(rdy), .REQ_ADDR(ra), .REQ_WE(rwe), .REQ_SEL(rsel), .REQ_WDATA(rwd), .RSP_VALID(rsv),
    .RSP_ERR(rse), .RSP_RDATA(rrd), .IO_ADDR(ioa), .IO_BANK_SELECT_N(csn), .READ_STROBE_N(rdn),
    .WRITE_STROBE_N(wrn), .BYTE_WRITE_STROBE_N(bwn), .IO_DATA_OUT(iodo), .IO_DATA_OE(ioe), .IO_DATA_IN(din),
    .SD_REQ_VALID(sdv), .SD_REQ_READY(sdr), .SD_REQ_BANK(sdb), .SD_REQ_WE(sdwe), .SD_DONE(sdd), .SD_CMD(cmd),
    .SD_CMD_BANK(cb), .SD_INIT_BUSY(busy), .MCLK_TREE_TAP(tap), .MCLK_OUT_DELAY(mod), .LATCH_CLOCK_SKEW_SEL(lsk));
  io_dev_model #(.KEY(KEY)) i_io_dev_model (.clk(CLK), .sel_n(csn), .rd_n(rdn), .wr_n(wrn), .addr(ioa),
    .dout(iodo), .din(din), .wr_last(wlast));
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo;
    fail_count++;
    tally_and_finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] pinf(input logic [31:0] x, f);
    return (f[15] || f[1:0] == 2'h1) ? x : x >> (f[1:0] - 2'h1);
  endfunction
  function automatic int lenf(input logic [3:0] v);
    return v == 4'h0 ? 1 : v < 4'h8 ? int'(v) : 2 * int'(v) - 7;
  endfunction
  task automatic wb(input logic w, input logic [31:0] ad, d, input logic [3:0] s);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    sel <= s;
    n = 0;
    do @(posedge CLK); while (ack !== 1'b1 && ++n < 40);
    if (n >= 40) tmo;
    rdq = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] ad);
    wb(1'b0, ad, 32'h0, 4'hF);
  endtask
  task automatic sd(input logic b);
    @(posedge CLK);
    sdv <= 1'b1;
    sdb <= b;
    sdwe <= 1'($random(seed));
    n = 0;
    do @(posedge CLK); while (sdr !== 1'b1 && ++n < 50);
    sdv <= 1'b0;
    t = 0;
    t0 = 0;
    while (sdd !== 1'b1 && ++t < 200)
    begin
      @(negedge CLK);
      if (cmd === `SD_CMD_ACTIVE)
      begin
        t0 = t;
        chk(cb, b);
      end
      if (cmd === `SD_CMD_READ || cmd === `SD_CMD_WRITE) chk(t - t0, tm[b][10:8] + 1);
      if (cmd === `SD_CMD_PRECHARGE)
      begin
        t1 = tm[b][10:8] + (sdwe ? tm[b][7:6] : 2'h0) + 2;
        chk(t - t0, t1 > tm[b][2:0] + 1 ? t1 : tm[b][2:0] + 1);
        t0 = t;
      end
      if (sdd === 1'b1) chk(t - t0, tm[b][5:3] + 1);
    end
    if (n >= 50 || t >= 200) tmo;
  endtask
  task automatic io(input logic [31:0] ad, input logic w);
    @(posedge CLK);
    rv <= 1'b1;
    ra <= ad;
    rwe <= w;
    rsel <= 4'($random(seed));
    wd = $random(seed);
    rwd <= wd;
    n = 0;
    do @(posedge CLK); while (rdy !== 1'b1 && ++n < 50);
    rv <= 1'b0;
    c = '{0, 0, 0, 0};
    t = 0;
    while (rsv !== 1'b1 && ++n < 300)
    begin
      @(negedge CLK);
      if (!wrn) chk(bwn ^ rsel, 4'hF);
      if (!rdn || !wrn)
      begin
        c[2]++;
        t = 1;
      end
      else if (csn !== 4'hF)
        c[t ? 3 : 1]++;
      else if (!t && ioa === pinf(ad, cfg))
        c[0]++;
    end
    if (n >= 300) tmo;
  endtask
  initial
  begin
    {NRST, cyc, stb, we, rv, rwe, sdv, sdb, sdwe} = '0;
    {adr, dat, ra, rwd, sel, rsel} = '0;
    tap = 8'($random(seed));
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    for (n = 0; busy !== 1'b0 && n < 300; n++) @(posedge CLK);
    if (n >= 300) tmo;
    for (k = 0; k < 6; k++)
    begin
      rd(`ADDR_SDRAM_BANK0_TIMING + 4 * k);
      chk(rdq, 32'h0);
    end
    rd(`ADDR_CLOCK_SKEW_CONTROL);
    chk(rdq, {tap, tap, 16'h0018});
    wb(1'b1, 32'hFFF01028, 32'hFFFFFFFF, 4'hF);
    rd(32'hFFF01028);
    chk(rdq, 32'h0);
    for (k = 0; k < 2; k++)
    begin
      tm[k] = $random(seed) | (k ? 32'h0 : 32'h38);
      wb(1'b1, `ADDR_SDRAM_BANK0_TIMING + 4 * k, tm[k], 4'hF);
      rd(`ADDR_SDRAM_BANK0_TIMING + 4 * k);
      chk(rdq, tm[k] & 32'h7FF);
    end
    for (k = 0; k < 4; k++) sd(k[0]);
    wd = $random(seed);
    wb(1'b1, `ADDR_CLOCK_SKEW_CONTROL, wd, 4'h1);
    @(negedge CLK);
    chk({lsk, mod}, wd[7:0]);
    wb(1'b1, `ADDR_CLOCK_SKEW_CONTROL, 32'h100, 4'h2);
    rd(`ADDR_CLOCK_SKEW_CONTROL);
    chk(rdq[8], 1'b1);
    for (k = 0; rdq[8] !== 1'b0 && k < 30; k++) rd(`ADDR_CLOCK_SKEW_CONTROL);
    if (k >= 30) tmo;
    for (k = 0; k < 8; k++)
    begin
      cfg = $random(seed);
      cfg[31:11] = {13'((k % 4 + 1) * 128), 3'(k % 4), 1'b0, 4'(k + 3)};
      cfg[1:0] = 2'(k % 3 + 1);
      wb(1'b1, `ADDR_IO_BANK0_CONTROL + 4 * (k % 4), cfg, 4'hF);
      rd(`ADDR_IO_BANK0_CONTROL + 4 * (k % 4));
      chk(rdq, cfg);
      sz = 32'h40000 << cfg[18:16];
      a = {cfg[31:19], 18'h0} + (k < 4 ? sz - 32'h4 : 32'h0);
      io(a, 1'($random(seed)));
      chk(c[0], cfg[7:5]);
      chk(c[1], cfg[4:2] + 1);
      chk(c[2], lenf(cfg[14:11]));
      chk(c[3], cfg[10:8] + 1);
      chk(rse, 1'b0);
      chk(rwe ? wlast : rrd, rwe ? wd : pinf(a, cfg) ^ KEY);
      io({cfg[31:19], 18'h0} + sz, 1'b0);
      chk({rse, c[2][0]}, 2'h2);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
